// [rtl/wdg_cnt_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface wdg_cnt_if;
   logic       run;
   logic       clear;
   logic [2:0] period;
   logic       expire;
   modport ctrl (output run, output clear, output period, input expire);
   modport cnt  (input run, input clear, input period, output expire);
endinterface : wdg_cnt_if
`default_nettype wire

// [rtl/wdg_counter.sv]
`timescale 1ns/1ps
`default_nettype none
`include "wdg_defines.svh"
module wdg_counter (
   input  wire logic    ref_clk_i,
   input  wire logic    rst_i,
   wdg_cnt_if.cnt       cnt_if
);
   import wdg_pkg::*;

   logic [`WDG_PRE_W-1:0] pre_r;
   logic [`WDG_TMR_W-1:0] tmr_r;
   logic [`WDG_PRE_W-1:0] pre_top;

   // prescaler wraps at 2^ps - 1, so period = 16K * 2^ps
   assign pre_top = `WDG_PRE_ALL >> (`WDG_PRE_W - cnt_if.period);

   always_ff @(posedge ref_clk_i) begin
      if (rst_i || cnt_if.clear) begin
         pre_r <= `WDG_PRE_ZERO;
         tmr_r <= `WDG_TMR_ZERO;
      end else if (cnt_if.run) begin
         if (pre_r >= pre_top) begin
            pre_r <= `WDG_PRE_ZERO;
            tmr_r <= tmr_r + 14'h0001;
         end else begin
            pre_r <= pre_r + 7'h01;
         end
      end
   end

   assign cnt_if.expire = cnt_if.run && !cnt_if.clear && (pre_r >= pre_top) && (tmr_r == `WDG_TMR_ALL);
endmodule : wdg_counter
`default_nettype wire

// [rtl/wdg_defines.svh]
`ifndef WDG_DEFINES_SVH
`define WDG_DEFINES_SVH
// special function register addresses
`define WDG_KEY_ADDR        8'hA6
`define WDG_CTRL_ADDR       8'hA7
// key bytes
`define WDG_KEY_FIRST       8'h1E
`define WDG_KEY_SECOND      8'hE1
// control register layout
`define WDG_CTRL_RESET      8'h00
`define WDG_PS_RESET        3'h0
`define WDG_RD_ZERO         8'h00
`define WDG_PS_HI           7
`define WDG_PS_LO           5
`define WDG_IDLE_BIT        4
`define WDG_OVF_BIT         1
`define WDG_RUN_BIT         0
// counter widths and base period
`define WDG_PRE_W           7
`define WDG_TMR_W           14
`define WDG_PS_W            3
`define WDG_BASE_SHIFT      4'hE
`define WDG_TMR_ZERO        14'h0000
`define WDG_TMR_ALL         14'h3FFF
`define WDG_PRE_ZERO        7'h00
`define WDG_PRE_ALL         7'h7F
`endif

// [rtl/wdg_pkg.sv]
package wdg_pkg;
   typedef logic [7:0] wdg_byte_t;
   // key sequencer states, gray along the usual path
   typedef enum logic [1:0] {
      WDG_KEY_IDLE = 2'b00,
      WDG_KEY_HALF = 2'b01,
      WDG_KEY_BAD  = 2'b11
   } wdg_key_state_t;
endpackage : wdg_pkg

// [rtl/wdg_top.sv]
`timescale 1ns/1ps
`default_nettype none
`include "wdg_defines.svh"
module wdg_top (
   input  wire logic            ref_clk_i,
   input  wire logic            rst_i,
   input  wire logic            sfr_wr_i,
   input  wire logic            sfr_rd_i,
   input  wire logic [7:0]      sfr_addr_i,
   input  wire logic [7:0]      sfr_wdata_i,
   input  wire logic            idle_i,
   input  wire logic            power_down_i,
   output logic [7:0]           sfr_rdata_o,
   output logic                 cpu_reset_o
);
   import wdg_pkg::*;

   wdg_cnt_if                   cnt_bus ();
   wdg_key_state_t              key_r;
   logic [`WDG_PS_W-1:0]        period_r;
   logic                        idle_freeze_r;
   logic                        overflow_flag_r;
   logic                        running_flag_r;
   logic                        key_wr;
   logic                        ctrl_wr;
   logic                        feed_ok;
   logic                        key_fail;
   logic                        trip;
   // key sequence decode, trip and counter control, overflow clear and control read view
   logic                        other_wr;
   logic                        key_idle;
   logic                        key_busy;
   logic                        first_byte;
   logic                        second_byte;
   logic                        bad_first;
   logic                        bad_second;
   logic                        broken_seq;
   logic                        timeout;
   logic                        restart;
   logic                        ovf_clear;
   logic                        halted;
   logic                        frozen;
   wdg_byte_t                   ctrl_view;

   // address decode: only two registers are ours, but any other write
   // still matters because it can break a half-done key sequence
   always_comb begin
      key_wr   = 1'b0;
      ctrl_wr  = 1'b0;
      other_wr = 1'b0;
      if (sfr_addr_i == `WDG_KEY_ADDR) begin
         key_wr   = sfr_wr_i;
      end else if (sfr_addr_i == `WDG_CTRL_ADDR) begin
         ctrl_wr  = sfr_wr_i;
         other_wr = sfr_wr_i;
      end else begin
         other_wr = sfr_wr_i;
      end
   end

   // sequencer decode
   assign key_idle    = (key_r == WDG_KEY_IDLE);
   assign key_busy    = (key_r == WDG_KEY_HALF);
   assign first_byte  = (sfr_wdata_i == `WDG_KEY_FIRST);
   assign second_byte = (sfr_wdata_i == `WDG_KEY_SECOND);

   assign feed_ok    = key_busy && key_wr && second_byte;
   assign bad_first  = key_idle && key_wr && !first_byte;
   // wrong second byte
   // a repeated first byte lands here too, since the order is wrong
   assign bad_second = key_busy && key_wr && !second_byte;
   assign broken_seq = key_busy && other_wr;
   assign key_fail   = bad_first || bad_second || broken_seq;
   // expiry without feed
   // the counter gates expiry with run, so a frozen count never trips
   assign timeout    = cnt_bus.expire;
   assign trip       = key_fail || timeout;

   // key sequencer; reads between the bytes leave it alone
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         key_r <= WDG_KEY_IDLE;
      end else begin
         case (key_r)
            WDG_KEY_IDLE: begin
               if (key_wr && sfr_wdata_i == `WDG_KEY_FIRST) begin
                  key_r <= WDG_KEY_HALF;
               end
            end
            WDG_KEY_HALF: begin
               if (sfr_wr_i) begin
                  key_r <= WDG_KEY_IDLE;
               end
            end
            default: begin
               key_r <= WDG_KEY_IDLE;
            end
         endcase
      end
   end

   // running from the second key byte on
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         running_flag_r <= 1'b0;
      end else if (trip) begin
         // the reset pulse disables; software re-enables
         running_flag_r <= 1'b0;
      end else if (feed_ok) begin
         running_flag_r <= 1'b1;
      end
   end

   // period select, acts on the running count at once
   // lowering it mid-count is safe, the prescaler compares with >=
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         period_r <= `WDG_PS_RESET;
      end else if (ctrl_wr) begin
         period_r <= sfr_wdata_i[`WDG_PS_HI:`WDG_PS_LO];
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         idle_freeze_r <= 1'b0;
      end else if (ctrl_wr) begin
         idle_freeze_r <= sfr_wdata_i[`WDG_IDLE_BIT];
      end
   end

   // software clears by writing zero to the flag; writing one keeps it,
   // so a read-modify-write of the other fields cannot lose an event
   assign ovf_clear = ctrl_wr && !sfr_wdata_i[`WDG_OVF_BIT];

   // set wins over clear; survives trip
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         overflow_flag_r <= 1'b0;
      end else if (trip) begin
         overflow_flag_r <= 1'b1;
      end else if (ovf_clear) begin
         overflow_flag_r <= 1'b0;
      end
   end

   // internal reset pulse, one cycle per cycle that trips
   // registered so the pulse is clean; back-to-back bad key writes stretch it over several cycles
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         cpu_reset_o <= 1'b0;
      end else begin
         cpu_reset_o <= trip;
      end
   end

   // control view, running flag read-only; unused bits read zero
   // built field by field so the layout lives in the defines
   always_comb begin
      ctrl_view                        = `WDG_CTRL_RESET;
      ctrl_view[`WDG_PS_HI:`WDG_PS_LO] = period_r;
      ctrl_view[`WDG_IDLE_BIT]         = idle_freeze_r;
      ctrl_view[`WDG_OVF_BIT]          = overflow_flag_r;
      ctrl_view[`WDG_RUN_BIT]          = running_flag_r;
   end

   // read data stands one cycle and then drops back to zero
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         sfr_rdata_o <= `WDG_RD_ZERO;
      end else if (!sfr_rd_i) begin
         sfr_rdata_o <= `WDG_RD_ZERO;
      end else if (sfr_addr_i == `WDG_CTRL_ADDR) begin
         sfr_rdata_o <= ctrl_view;
      end else if (sfr_addr_i == `WDG_KEY_ADDR) begin
         sfr_rdata_o <= `WDG_RD_ZERO;
      end else begin
         // foreign addresses belong to other blocks
         sfr_rdata_o <= `WDG_RD_ZERO;
      end
   end

   assign halted  = power_down_i;
   assign frozen  = idle_i && idle_freeze_r;
   assign restart = feed_ok;

   assign cnt_bus.run    = running_flag_r && !halted && !frozen;
   // expiry stays out of clear: expire already looks at clear, so it would loop;
   // a trip drops the running flag and the stopped watchdog clears a cycle later
   assign cnt_bus.clear  = restart || key_fail || !running_flag_r;
   assign cnt_bus.period = period_r;

   wdg_counter u_counter (
      .ref_clk_i (ref_clk_i),
      .rst_i     (rst_i),
      .cnt_if    (cnt_bus.cnt)
   );
endmodule : wdg_top
`default_nettype wire

// [tb/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin miscompares++; \
   $display("Error %0t got %h exp %h", $time, g, e); end end
module tb_top;
   logic       ref_clk_i = 1'h0, rst_i = 1'h1, sfr_wr_i = 1'h0, sfr_rd_i = 1'h0;
   logic       idle_i = 1'h0, power_down_i = 1'h0, cpu_reset_o;
   logic [7:0] sfr_addr_i = 8'h00, sfr_wdata_i = 8'h00, sfr_rdata_o;
   int         miscompares = 0, n_tests = 0, c;
   always #4 ref_clk_i = ~ref_clk_i;
   wdg_top dut_u (.ref_clk_i, .rst_i, .sfr_wr_i, .sfr_rd_i, .sfr_addr_i, .sfr_wdata_i,
      .idle_i, .power_down_i, .sfr_rdata_o, .cpu_reset_o);
   task op(input logic w, r, input logic [7:0] a, d);
      sfr_wr_i = w;
      sfr_rd_i = r;
      sfr_addr_i = a;
      sfr_wdata_i = d;
      @(negedge ref_clk_i);
   endtask : op
   task wr(input logic [7:0] a, d);
      op(1'h1, 1'h0, a, d);
   endtask : wr
   task rd(input logic [7:0] e);
      op(1'h0, 1'h1, 8'hA7, 8'h00);
      `CHK(sfr_rdata_o, e)
   endtask : rd
   task key();
      wr(8'hA6, 8'h1E);
      wr(8'hA6, 8'hE1);
   endtask : key
   // idle cycles until the watchdog fires or the limit runs out
   task run(input int lim);
      c = 0;
      while (c < lim && cpu_reset_o !== 1'h1) begin
         op(1'h0, 1'h0, 8'h00, 8'h00);
         c++;
      end
   endtask : run
   task tmo(input int n);
      run(n + 16);
      `CHK(c, n)
   endtask : tmo
   task stop_test();
      if (miscompares == 0 && n_tests > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : stop_test
   initial begin
      #(8 * 90000);
      miscompares++;
      stop_test();
   end
   initial begin
      logic [7:0] bad [3] = '{8'h55, 8'hE1, 8'h1F};
      repeat (8) @(negedge ref_clk_i);
      rst_i = 1'h0;
      rd(8'h00);
      wr(8'hA7, 8'hFF);
      rd(8'hF0);
      op(1'h0, 1'h1, 8'hA6, 8'h00);
      `CHK(sfr_rdata_o, 8'h00)
      foreach (bad[i]) begin
         wr(8'hA6, bad[i]);
         `CHK(cpu_reset_o, 1'h1)
      end
      wr(8'hA6, 8'h1E);
      wr(8'hA7, 8'h00);
      `CHK(cpu_reset_o, 1'h1)
      rd(8'h02);
      wr(8'hA7, 8'h00);
      rd(8'h00);
      wr(8'hA6, 8'h1E);
      rd(8'h00);
      wr(8'hA6, 8'hE1);
      `CHK(cpu_reset_o, 1'h0)
      wr(8'hA7, 8'h00);
      rd(8'h01);
      run(10000);
      `CHK(c, 10000)
      key();
      tmo(16384);
      rd(8'h02);
      wr(8'hA7, 8'h30);
      rd(8'h30);
      key();
      idle_i = 1'h1;
      run(3000);
      `CHK(c, 3000)
      idle_i = 1'h0;
      tmo(32768);
      wr(8'hA7, 8'h00);
      key();
      power_down_i = 1'h1;
      run(3000);
      `CHK(c, 3000)
      power_down_i = 1'h0;
      tmo(16384);
      key();
      rst_i = 1'h1;
      repeat (8) op(1'h0, 1'h0, 8'h00, 8'h00);
      rst_i = 1'h0;
      op(1'h0, 1'h0, 8'h00, 8'h00);
      rd(8'h00);
      stop_test();
   end
endmodule : tb_top
bind wdg_top wdg_properties chk_u (.ref_clk_i, .rst_i, .sfr_wr_i, .sfr_rd_i, .sfr_addr_i,
   .sfr_wdata_i, .idle_i, .power_down_i, .sfr_rdata_o, .cpu_reset_o);
`default_nettype wire

// [tb/wdg_properties.sv]
`timescale 1ns/1ps
`default_nettype none
module wdg_properties (
   input wire logic       ref_clk_i,
   input wire logic       rst_i,
   input wire logic       sfr_wr_i,
   input wire logic       sfr_rd_i,
   input wire logic [7:0] sfr_addr_i,
   input wire logic [7:0] sfr_wdata_i,
   input wire logic       idle_i,
   input wire logic       power_down_i,
   input wire logic [7:0] sfr_rdata_o,
   input wire logic       cpu_reset_o
);
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (rst_i);
   sequence key1_s; sfr_wr_i && sfr_addr_i == 8'hA6 && sfr_wdata_i == 8'h1E; endsequence
   sequence key2_s; sfr_wr_i && sfr_addr_i == 8'hA6 && sfr_wdata_i == 8'hE1; endsequence
   bad_key_a: assert property (
      sfr_wr_i && sfr_addr_i == 8'hA6 && sfr_wdata_i != 8'hE1 && sfr_wdata_i != 8'h1E
      |=> cpu_reset_o) else $error("bad key byte not punished");
   good_seq_a: assert property (key1_s ##1 key2_s |=> !cpu_reset_o) else $error("good key tripped");
   break_seq_a: assert property (
      key1_s ##1 (sfr_wr_i && sfr_addr_i != 8'hA6) |=> cpu_reset_o) else $error("broken key not punished");
   read_between_a: assert property (
      key1_s ##1 (!sfr_wr_i && sfr_rd_i) ##1 key2_s |=> !cpu_reset_o) else $error("read broke key");
   pulse_once_a: assert property (cpu_reset_o && !sfr_wr_i |=> !cpu_reset_o) else $error("reset pulse too long");
   read_idle_a: assert property (!sfr_rd_i |=> sfr_rdata_o == 8'h00) else $error("stale read data");
   key_read_a: assert property (
      sfr_rd_i && sfr_addr_i != 8'hA7 |=> sfr_rdata_o == 8'h00) else $error("key register readable");
   unused_bits_a: assert property (sfr_rd_i |=> sfr_rdata_o[3:2] == 2'h0) else $error("unused bits set");
   release_quiet_a: assert property ($fell(rst_i) |-> !cpu_reset_o) else $error("reset after release");
endmodule : wdg_properties
`default_nettype wire
